// *** jbt_consts.svh ***
// Constants of the boundary-scan test port: opcodes, widths, identity
`ifndef JBT_CONSTS_SVH
`define JBT_CONSTS_SVH

`define JBT_IR_W 10
`define JBT_DR32_W 32
`define JBT_CFG_W 8

`define JBT_OP_EXTEST 10'h000
`define JBT_OP_CFG 10'h002
`define JBT_OP_SAMPLE 10'h005
`define JBT_OP_IDCODE 10'h006
`define JBT_OP_USERCODE 10'h007
`define JBT_OP_ANA 10'h00E
`define JBT_OP_BYPASS 10'h3FF

// Low two bits 01 as the scan standard demands
`define JBT_IR_CAPT 10'h001

`define JBT_BSR_MIN 420
`define JBT_BSR_MAX 2190
`define JBT_BSR_DEF 420

// Identity fields; values are arbitrary
`define JBT_ID_VER 4'h1
`define JBT_ID_PART 16'h5A3C
`define JBT_ID_MFR 11'h2B5

`endif

// *** jbt_pkg.sv ***
// Types shared by the test port modules
package jbt_pkg;

	typedef enum logic [3:0] {
		ST_TLR, ST_RTI, ST_SELDR, ST_CAPDR, ST_SHDR, ST_EX1DR,
		ST_PSDR, ST_EX2DR, ST_UPDR, ST_SELIR, ST_CAPIR, ST_SHIR,
		ST_EX1IR, ST_PSIR, ST_EX2IR, ST_UPIR
	} jbt_state_t;

	typedef enum logic [2:0] {
		SEL_BYP, SEL_BSR, SEL_ID, SEL_USR, SEL_CFG, SEL_ANA
	} jbt_sel_t;

endpackage

// *** jbt_tap_if.sv ***
// Controller state decodes passed from the state machine to the data paths
`timescale 1ns/1ps
interface jbt_tap_if;
	logic tlr;
	logic cap_dr;
	logic sh_dr;
	logic up_dr;
	logic cap_ir;
	logic sh_ir;
	logic up_ir;
	logic hold;
	modport fsm(output tlr, cap_dr, sh_dr, up_dr, cap_ir, sh_ir, up_ir,
		hold);
	modport core(input tlr, cap_dr, sh_dr, up_dr, cap_ir, sh_ir, up_ir,
		hold);
endinterface

// *** jbt_sync.sv ***
// Two-flop synchroniser for levels and toggles
`timescale 1ns/1ps
module jbt_sync #(
	parameter int W = 1 // bits carried
) (
	input wire logic clk, // destination clock
	input wire logic [W-1:0] d, // foreign level
	output logic [W-1:0] q // synchronised level
);
	logic [W-1:0] meta_q;

	if (W < 1) begin : g_chk
		$error("synchroniser width must be positive");
	end

	always_ff @(posedge clk) begin
		meta_q <= d;
		q <= meta_q;
	end
endmodule

// *** jbt_tap_fsm.sv ***
// Sixteen-state test access port controller on the test clock
`timescale 1ns/1ps
module jbt_tap_fsm import jbt_pkg::*; (
	input wire logic tck, // test clock
	input wire logic rst_t, // reset, test clock domain
	input wire logic tms, // mode select
	jbt_tap_if.fsm tp // state decodes
);
	jbt_state_t st_q;
	jbt_state_t st_d;

	always_comb begin
		unique case (st_q)
			ST_TLR: st_d = tms ? ST_TLR : ST_RTI;
			ST_RTI: st_d = tms ? ST_SELDR : ST_RTI;
			ST_SELDR: st_d = tms ? ST_SELIR : ST_CAPDR;
			ST_CAPDR: st_d = tms ? ST_EX1DR : ST_SHDR;
			ST_SHDR: st_d = tms ? ST_EX1DR : ST_SHDR;
			ST_EX1DR: st_d = tms ? ST_UPDR : ST_PSDR;
			ST_PSDR: st_d = tms ? ST_EX2DR : ST_PSDR;
			ST_EX2DR: st_d = tms ? ST_UPDR : ST_SHDR;
			ST_UPDR: st_d = tms ? ST_SELDR : ST_RTI;
			ST_SELIR: st_d = tms ? ST_TLR : ST_CAPIR;
			ST_CAPIR: st_d = tms ? ST_EX1IR : ST_SHIR;
			ST_SHIR: st_d = tms ? ST_EX1IR : ST_SHIR;
			ST_EX1IR: st_d = tms ? ST_UPIR : ST_PSIR;
			ST_PSIR: st_d = tms ? ST_EX2IR : ST_PSIR;
			ST_EX2IR: st_d = tms ? ST_UPIR : ST_SHIR;
			ST_UPIR: st_d = tms ? ST_SELDR : ST_RTI;
		endcase
	end

	always_ff @(posedge tck) begin
		if (rst_t) begin
			st_q <= ST_TLR;
			tp.hold <= 1'b0;
		end else begin
			st_q <= st_d;
			// Freeze request leads the capture edge by two full periods
			tp.hold <= (st_d == ST_SELDR) || (st_d == ST_CAPDR);
		end
	end

	assign tp.tlr = (st_q == ST_TLR);
	assign tp.cap_dr = (st_q == ST_CAPDR);
	assign tp.sh_dr = (st_q == ST_SHDR);
	assign tp.up_dr = (st_q == ST_UPDR);
	assign tp.cap_ir = (st_q == ST_CAPIR);
	assign tp.sh_ir = (st_q == ST_SHIR);
	assign tp.up_ir = (st_q == ST_UPIR);
endmodule

// *** jbt_tap.sv ***
// Boundary-scan test port: instruction and data paths, core-side crossing
`timescale 1ns/1ps
`include "jbt_consts.svh"
module jbt_tap import jbt_pkg::*; #(
	parameter int BSR_LEN = `JBT_BSR_DEF, // boundary cells
	parameter bit BYPASS_ONLY = 1'b0, // smallest variant
	// Identity fields: values are arbitrary
	parameter logic [3:0] ID_VER = `JBT_ID_VER, // version
	parameter logic [15:0] ID_PART = `JBT_ID_PART, // part number
	parameter logic [10:0] ID_MFR = `JBT_ID_MFR // maker code
) (
	input wire logic sys_clk, // core clock
	input wire logic rst, // sync reset, high
	input wire logic tck, // test clock
	input wire logic tms, // test mode select
	input wire logic tdi, // serial data in
	output logic tdo, // serial data out
	output logic tdo_oe, // TDO driven
	input wire logic cfg_busy, // configuration running
	input wire logic [BSR_LEN-1:0] pin_in, // pin levels
	input wire logic [BSR_LEN-1:0] core_out, // core pin drive
	output logic [BSR_LEN-1:0] pin_out, // pin drive
	input wire logic [31:0] user_code, // programmed code
	input wire logic [31:0] probe, // watched signals
	output logic [7:0] cfg_byte, // config byte
	output logic cfg_stb, // config byte strobe
	output logic [31:0] ana_ctl, // analyser control
	output logic ana_stb, // analyser strobe
	output logic bst_refused // scan refused pulse
);
	localparam int IRW = `JBT_IR_W;
	localparam int DRW = `JBT_DR32_W;
	localparam int CFW = `JBT_CFG_W;
	localparam logic [IRW-1:0] RST_OP =
		BYPASS_ONLY ? `JBT_OP_BYPASS : `JBT_OP_IDCODE;
	localparam logic [DRW-1:0] ID_WORD =
		{ID_VER, ID_PART, ID_MFR, 1'b1};

	if (BYPASS_ONLY && BSR_LEN != 1) begin : g_chk_byp
		$error("bypass-only variant needs a one-cell chain");
	end
	if (!BYPASS_ONLY && (BSR_LEN < `JBT_BSR_MIN ||
		BSR_LEN > `JBT_BSR_MAX)) begin : g_chk_len
		$error("boundary chain length out of range");
	end

	// Path for an opcode; busy configuration refuses boundary scan
	function automatic jbt_sel_t dec(input logic [IRW-1:0] op,
		input logic busy);
		jbt_sel_t s;
		s = SEL_BYP;
		if (!BYPASS_ONLY) begin
			case (op)
				`JBT_OP_SAMPLE,
				`JBT_OP_EXTEST: s = busy ? SEL_BYP : SEL_BSR;
				`JBT_OP_IDCODE: s = SEL_ID;
				`JBT_OP_USERCODE: s = SEL_USR;
				`JBT_OP_CFG: s = SEL_CFG;
				`JBT_OP_ANA: s = SEL_ANA;
				default: s = SEL_BYP;
			endcase
		end
		return s;
	endfunction

	function automatic logic is_bst(input logic [IRW-1:0] op);
		return op == `JBT_OP_SAMPLE || op == `JBT_OP_EXTEST;
	endfunction

	jbt_tap_if tif();

	logic rst_t;
	logic busy_t;
	logic t_clr;
	logic [IRW-1:0] ir_sh_q;
	logic [IRW-1:0] ir_q;
	jbt_sel_t sel_q;
	jbt_sel_t new_sel;
	logic ext_q;
	logic new_ext;
	logic byp_q;
	logic [BSR_LEN-1:0] bsr_sh_q;
	logic [BSR_LEN-1:0] bsr_upd_q;
	logic [BSR_LEN-1:0] bsr_shift;
	logic [DRW-1:0] dr32_q;
	logic [DRW-1:0] dr32_cap;
	logic [CFW-1:0] cfg_sh_q;
	logic [CFW-1:0] cfg_upd_q;
	logic [DRW-1:0] ana_upd_q;
	logic tgl_bsr_q;
	logic tgl_cfg_q;
	logic tgl_ana_q;
	logic tgl_ref_q;
	logic sel_bsr;
	logic sel_32;
	logic sel_cfg;
	logic sel_byp;
	logic dr_bit;
	logic tdo_d;
	logic refuse;

	logic [BSR_LEN-1:0] pin_s;
	logic hold_s;
	logic ext_s;
	logic tb_s;
	logic tc_s;
	logic ta_s;
	logic tr_s;
	logic [3:0] tgl_prev_q;
	logic bsr_ev;
	logic cfg_ev;
	logic ana_ev;
	logic ref_ev;
	logic [BSR_LEN-1:0] snap_q;
	logic [31:0] usr_q;
	logic [31:0] probe_q;
	logic [BSR_LEN-1:0] drv_q;
	logic drive_pins;

	// Test clock side: reset and busy arrive from the core domain
	jbt_sync #(.W(2)) u_tsync (
		.clk(tck),
		.d({rst, cfg_busy}),
		.q({rst_t, busy_t})
	);

	jbt_tap_fsm u_fsm (
		.tck(tck),
		.rst_t(rst_t),
		.tms(tms),
		.tp(tif.fsm)
	);

	assign t_clr = rst_t || tif.tlr;
	assign new_sel = dec(ir_sh_q, busy_t);
	assign new_ext = (ir_sh_q == `JBT_OP_EXTEST) && (new_sel == SEL_BSR);
	assign refuse = !BYPASS_ONLY && busy_t && is_bst(ir_sh_q);

	// Instruction shift and update stages
	always_ff @(posedge tck) begin
		if (t_clr || tif.cap_ir) begin
			ir_sh_q <= `JBT_IR_CAPT;
		end else if (tif.sh_ir) begin
			ir_sh_q <= {tdi, ir_sh_q[IRW-1:1]};
		end
	end

	always_ff @(posedge tck) begin
		if (t_clr) begin
			ir_q <= RST_OP;
			sel_q <= dec(RST_OP, 1'b0);
			ext_q <= 1'b0;
		end else if (tif.up_ir) begin
			ir_q <= ir_sh_q;
			sel_q <= new_sel;
			ext_q <= new_ext;
		end
	end

	always_ff @(posedge tck) begin
		if (rst_t) begin
			tgl_ref_q <= 1'b0;
		end else if (tif.up_ir && refuse) begin
			tgl_ref_q <= !tgl_ref_q;
		end
	end

	assign sel_bsr = (sel_q == SEL_BSR);
	assign sel_32 = (sel_q == SEL_ID) || (sel_q == SEL_USR) ||
		(sel_q == SEL_ANA);
	assign sel_cfg = (sel_q == SEL_CFG);
	assign sel_byp = (sel_q == SEL_BYP);

	// Bypass cell
	always_ff @(posedge tck) begin
		if (rst_t || (tif.cap_dr && sel_byp)) begin
			byp_q <= 1'b0;
		end else if (tif.sh_dr && sel_byp) begin
			byp_q <= tdi;
		end
	end

	// Shift works for a one-cell chain as well
	assign bsr_shift = (bsr_sh_q >> 1) |
		(BSR_LEN'(tdi) << (BSR_LEN - 1));

	// Boundary chain: capture the frozen pin snapshot, shift, update
	always_ff @(posedge tck) begin
		if (rst_t) begin
			bsr_sh_q <= '0;
		end else if (tif.cap_dr && sel_bsr) begin
			bsr_sh_q <= snap_q;
		end else if (tif.sh_dr && sel_bsr) begin
			bsr_sh_q <= bsr_shift;
		end
	end

	// Update stage keeps the preload across instruction changes
	always_ff @(posedge tck) begin
		if (rst_t) begin
			bsr_upd_q <= '0;
			tgl_bsr_q <= 1'b0;
		end else if (tif.up_dr && sel_bsr) begin
			bsr_upd_q <= bsr_sh_q;
			tgl_bsr_q <= !tgl_bsr_q;
		end
	end

	assign dr32_cap = (sel_q == SEL_ID) ? ID_WORD :
		(sel_q == SEL_USR) ? usr_q : probe_q;

	// Shared 32-bit path for identity, user code and analyser
	always_ff @(posedge tck) begin
		if (rst_t) begin
			dr32_q <= '0;
		end else if (tif.cap_dr && sel_32) begin
			dr32_q <= dr32_cap;
		end else if (tif.sh_dr && sel_32) begin
			dr32_q <= {tdi, dr32_q[DRW-1:1]};
		end
	end

	always_ff @(posedge tck) begin
		if (rst_t) begin
			ana_upd_q <= '0;
			tgl_ana_q <= 1'b0;
		end else if (tif.up_dr && (sel_q == SEL_ANA)) begin
			ana_upd_q <= dr32_q;
			tgl_ana_q <= !tgl_ana_q;
		end
	end

	// Configuration path; capture reports whether loading is in progress
	always_ff @(posedge tck) begin
		if (rst_t) begin
			cfg_sh_q <= '0;
		end else if (tif.cap_dr && sel_cfg) begin
			cfg_sh_q <= {{(CFW-1){1'b0}}, busy_t};
		end else if (tif.sh_dr && sel_cfg) begin
			cfg_sh_q <= {tdi, cfg_sh_q[CFW-1:1]};
		end
	end

	always_ff @(posedge tck) begin
		if (rst_t) begin
			cfg_upd_q <= '0;
			tgl_cfg_q <= 1'b0;
		end else if (tif.up_dr && sel_cfg) begin
			cfg_upd_q <= cfg_sh_q;
			tgl_cfg_q <= !tgl_cfg_q;
		end
	end

	assign dr_bit = sel_bsr ? bsr_sh_q[0] :
		sel_32 ? dr32_q[0] :
		sel_cfg ? cfg_sh_q[0] : byp_q;
	assign tdo_d = tif.sh_ir ? ir_sh_q[0] : dr_bit;

	// TDO changes on the falling edge, giving the far end half a period
	always_ff @(negedge tck) begin
		if (rst_t) begin
			tdo <= 1'b0;
			tdo_oe <= 1'b0;
		end else begin
			tdo <= tdo_d;
			tdo_oe <= tif.sh_ir || tif.sh_dr;
		end
	end

	// Core clock side
	jbt_sync #(.W(BSR_LEN)) u_psync (
		.clk(sys_clk),
		.d(pin_in),
		.q(pin_s)
	);

	jbt_sync #(.W(6)) u_ssync (
		.clk(sys_clk),
		.d({tif.hold, ext_q, tgl_bsr_q, tgl_cfg_q, tgl_ana_q, tgl_ref_q}),
		.q({hold_s, ext_s, tb_s, tc_s, ta_s, tr_s})
	);

	assign bsr_ev = tb_s ^ tgl_prev_q[3];
	assign cfg_ev = tc_s ^ tgl_prev_q[2];
	assign ana_ev = ta_s ^ tgl_prev_q[1];
	assign ref_ev = tr_s ^ tgl_prev_q[0];
	assign drive_pins = ext_s && !cfg_busy;

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			tgl_prev_q <= '0;
		end else begin
			tgl_prev_q <= {tb_s, tc_s, ta_s, tr_s};
		end
	end

	// Frozen while a capture is pending, so the test clock reads a
	// stable word; relies on the test clock being far slower
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			snap_q <= '0;
			usr_q <= '0;
			probe_q <= '0;
		end else if (!hold_s) begin
			snap_q <= pin_s;
			usr_q <= user_code;
			probe_q <= probe;
		end
	end

	// Update word is held for several test clocks after its toggle
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			drv_q <= '0;
		end else if (bsr_ev) begin
			drv_q <= bsr_upd_q;
		end
	end

	// Sample leaves the core in charge of the pins
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			pin_out <= '0;
		end else begin
			pin_out <= drive_pins ? drv_q : core_out;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			cfg_byte <= '0;
			cfg_stb <= 1'b0;
			bst_refused <= 1'b0;
		end else begin
			bst_refused <= ref_ev;
			cfg_stb <= cfg_ev;
			if (cfg_ev) begin
				cfg_byte <= cfg_upd_q;
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			ana_ctl <= '0;
			ana_stb <= 1'b0;
		end else begin
			ana_stb <= ana_ev;
			if (ana_ev) begin
				ana_ctl <= ana_upd_q;
			end
		end
	end
endmodule

// *** jbt_tap_assertions.sv ***
// Concurrent checks on the test port pins
`timescale 1ns/1ps
module jbt_tap_assertions #(
	parameter int BSR_LEN = 420 // cells
) (
	input logic sys_clk, // core clock
	input logic rst, // reset
	input logic tck, // test clock
	input logic tms, // mode
	input logic tdo, // serial out
	input logic tdo_oe, // out driven
	input logic cfg_busy, // config running
	input logic [BSR_LEN-1:0] core_out, // core drive
	input logic [BSR_LEN-1:0] pin_out, // pin drive
	input logic [7:0] cfg_byte, // config byte
	input logic cfg_stb, // config strobe
	input logic [31:0] ana_ctl, // analyser word
	input logic ana_stb, // analyser strobe
	input logic bst_refused // refusal
);
	sequence s_tlr;
		tms [*5];
	endsequence
	sequence s_to_shdr;
		!tms ##1 tms ##1 !tms ##1 !tms;
	endsequence
	sequence s_to_shir;
		!tms ##1 tms [*2] ##1 !tms [*2];
	endsequence
	property p_tlr_quiet;
		@(posedge tck) disable iff (rst) s_tlr |=> !tdo_oe;
	endproperty
	a_tlr_quiet: assert property (p_tlr_quiet)
		else $error("tdo driven after reset sequence");
	property p_id_first;
		@(posedge tck) disable iff (rst) s_tlr ##1 s_to_shdr |=> tdo_oe && tdo;
	endproperty
	a_id_first: assert property (p_id_first)
		else $error("identity does not start with one");
	property p_ir_capt;
		@(posedge tck) disable iff (rst)
			s_tlr ##1 s_to_shir |=> tdo_oe && tdo ##1 !tdo;
	endproperty
	a_ir_capt: assert property (p_ir_capt)
		else $error("instruction capture value wrong");
	property p_cfg_pulse;
		@(posedge sys_clk) disable iff (rst) cfg_stb |=> !cfg_stb;
	endproperty
	a_cfg_pulse: assert property (p_cfg_pulse)
		else $error("config strobe too long");
	property p_cfg_new;
		@(posedge sys_clk) disable iff (rst) $changed(cfg_byte) |-> cfg_stb;
	endproperty
	a_cfg_new: assert property (p_cfg_new)
		else $error("config byte changed without strobe");
	property p_ana_new;
		@(posedge sys_clk) disable iff (rst) $changed(ana_ctl) |-> ana_stb;
	endproperty
	a_ana_new: assert property (p_ana_new)
		else $error("analyser word changed without strobe");
	property p_ref_pulse;
		@(posedge sys_clk) disable iff (rst) bst_refused |=> !bst_refused;
	endproperty
	a_ref_pulse: assert property (p_ref_pulse)
		else $error("refusal pulse too long");
	// Configuration must take the pins back from the scan pattern
	property p_busy_pins;
		@(posedge sys_clk) disable iff (rst)
			cfg_busy [*6] |-> pin_out == $past(core_out);
	endproperty
	a_busy_pins: assert property (p_busy_pins)
		else $error("pins not core driven during config");
endmodule
bind jbt_tap jbt_tap_assertions #(.BSR_LEN(BSR_LEN)) jbt_tap_assertions_inst (
	.sys_clk(sys_clk), .rst(rst), .tck(tck), .tms(tms), .tdo(tdo),
	.tdo_oe(tdo_oe), .cfg_busy(cfg_busy), .core_out(core_out),
	.pin_out(pin_out), .cfg_byte(cfg_byte), .cfg_stb(cfg_stb),
	.ana_ctl(ana_ctl), .ana_stb(ana_stb), .bst_refused(bst_refused));

// *** jbt_host.sv ***
// Board test controller model for the serial test port
`timescale 1ns/1ps
module jbt_host (
	output logic tck, // idle low
	output logic tms, // mode
	output logic tdi, // serial data
	input wire logic tdo, // port data
	input wire logic tdo_oe // port drives
);
	initial begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b1;
	end
	// Released tdo reads as z, never as a stale bit
	task automatic step(input logic m, input logic d, output logic o);
		tms = m;
		tdi = d;
		#24;
		o = tdo_oe ? tdo : 1'bz;
		tck = 1'b1;
		#24;
		tck = 1'b0;
	endtask
	task automatic tlr();
		logic o;
		repeat (5) step(1'b1, ~tdi, o);
		step(1'b0, ~tdi, o);
	endtask
	task automatic scan(input bit ir, input int n, input logic [511:0] din,
		output logic [511:0] dout);
		logic o;
		dout = '0;
		step(1'b1, ~tdi, o);
		if (ir) step(1'b1, ~tdi, o);
		step(1'b0, ~tdi, o);
		step(1'b0, ~tdi, o);
		for (int i = 0; i < n; i++) begin
			step(i == n - 1, din[i], o);
			dout[i] = o;
		end
		step(1'b1, ~tdi, o);
		step(1'b0, ~tdi, o);
	endtask
	task automatic ir(input logic [9:0] code, output logic [511:0] dout);
		scan(1'b1, 10, {502'h0, code}, dout);
	endtask
endmodule

// *** tb_jbt_tap.sv ***
// Self-checking bench for the boundary-scan test port
`timescale 1ns/1ps
`include "jbt_consts.svh"
module tb_jbt_tap;
	localparam int L = 420;
	logic sys_clk, rst, tck, tms, tdi, tdo, tdo_oe, cfg_busy;
	logic [L-1:0] pin_in, core_out, pin_out;
	logic [31:0] user_code, probe, ana_ctl;
	logic [7:0] cfg_byte;
	logic cfg_stb, ana_stb, bst_refused;
	logic [511:0] din, dout, v;
	logic [9:0] byp [3] = '{`JBT_OP_BYPASS, 10'h155, 10'h2A0};
	logic q [$];
	int error_cnt, compares, ev_cnt, e, ref_cnt;
	jbt_tap #(.BSR_LEN(L)) jbt_tap_inst (.sys_clk(sys_clk), .rst(rst),
		.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe),
		.cfg_busy(cfg_busy), .pin_in(pin_in), .core_out(core_out),
		.pin_out(pin_out), .user_code(user_code), .probe(probe),
		.cfg_byte(cfg_byte), .cfg_stb(cfg_stb), .ana_ctl(ana_ctl),
		.ana_stb(ana_stb), .bst_refused(bst_refused));
	jbt_host jbt_host_inst (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
		.tdo_oe(tdo_oe));
	initial begin
		sys_clk = 1'b0;
		forever #2.5 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) begin
		if (cfg_stb === 1'b1 || ana_stb === 1'b1 || bst_refused === 1'b1) begin
			ev_cnt <= ev_cnt + 1;
		end
		if (bst_refused === 1'b1) begin
			ref_cnt <= ref_cnt + 1;
		end
	end
	task automatic chk(input logic [511:0] got, input logic [511:0] exp);
		compares++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic end_sim();
		if (error_cnt == 0 && compares > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task automatic wait_ev(input int old);
		int k;
		for (k = 0; k < 40 && ev_cnt == old; k++) @(posedge sys_clk);
		if (k == 40) begin
			error_cnt++;
			end_sim();
		end
	endtask
	function automatic logic [511:0] rnd();
		logic [511:0] r;
		for (int i = 0; i < 16; i++) r = {r[479:0], $urandom()};
		return r;
	endfunction
	task automatic ir(input logic [9:0] code);
		jbt_host_inst.ir(code, dout);
		chk(dout, 512'h001);
	endtask
	task automatic dr(input int n);
		din = rnd();
		jbt_host_inst.scan(1'b0, n, din, dout);
	endtask
	initial begin
		void'($urandom(19));
		rst = 1'b1;
		cfg_busy = 1'b0;
		v = rnd();
		pin_in = v[L-1:0];
		v = rnd();
		core_out = v[L-1:0];
		user_code = v[511:480];
		probe = v[479:448];
		// Test clock must also tick inside reset
		fork
			repeat (12) @(posedge sys_clk);
			jbt_host_inst.tlr();
		join
		@(negedge sys_clk);
		rst = 1'b0;
		jbt_host_inst.tlr();
		dr(32);
		chk(dout, {`JBT_ID_VER, `JBT_ID_PART, `JBT_ID_MFR, 1'b1});
		// Second reset walk so the instruction capture check is reached
		jbt_host_inst.tlr();
		ir(`JBT_OP_USERCODE);
		dr(32);
		chk(dout, user_code);
		for (int j = 0; j < 3; j++) begin
			ir(byp[j]);
			dr(40);
			q = {1'b0};
			for (int i = 0; i < 39; i++) q.push_back(din[i]);
			v = '0;
			for (int i = 0; i < 40; i++) v[i] = q[i];
			chk(dout, v);
		end
		ir(`JBT_OP_SAMPLE);
		dr(L);
		chk(dout, pin_in);
		chk(pin_out, core_out);
		v = din;
		ir(`JBT_OP_EXTEST);
		repeat (6) @(posedge sys_clk);
		chk(pin_out, v[L-1:0]);
		dr(L);
		chk(dout, pin_in);
		@(negedge sys_clk);
		cfg_busy = 1'b1;
		e = ev_cnt;
		ir(`JBT_OP_EXTEST);
		wait_ev(e);
		chk(ref_cnt, 512'h1);
		chk(pin_out, core_out);
		dr(2);
		chk(dout, {510'h0, din[0], 1'b0});
		ir(`JBT_OP_CFG);
		e = ev_cnt;
		dr(8);
		chk(dout, 512'h1);
		wait_ev(e);
		chk(cfg_byte, din[7:0]);
		@(negedge sys_clk);
		cfg_busy = 1'b0;
		ir(`JBT_OP_ANA);
		e = ev_cnt;
		dr(32);
		chk(dout, probe);
		wait_ev(e);
		chk(ana_ctl, din[31:0]);
		chk(ref_cnt, 512'h1);
		end_sim();
	end
endmodule
